// File: rtl/nvrb_map.svh
// nvrb_map.svh: offsets, field positions and reset values of the nv config block.
// assumes: included by the package and the block; definitions only.
`ifndef NVRB_MAP_SVH
`define NVRB_MAP_SVH

// ==================================================================
// word indices (byte address = 4 * index)
`define NVRB_IDX_MISC_CFG      12'h1b2
`define NVRB_IDX_DESIGN_CAP    12'h1b3
`define NVRB_IDX_SBS_CFG       12'h1b4
`define NVRB_IDX_RELAX_CFG     12'h1b6
`define NVRB_IDX_CONVG_CFG     12'h1b7
`define NVRB_IDX_NV_CFG0       12'h1b8
`define NVRB_IDX_NV_CFG1       12'h1b9
`define NVRB_IDX_NV_CFG2       12'h1ba
`define NVRB_IDX_FULL_SOC_TH   12'h1c6
`define NVRB_IDX_TTF_CFG       12'h1c7
`define NVRB_IDX_JEITA_C       12'h1d8
`define NVRB_IDX_STEP_CHG      12'h1db
`define NVRB_IDX_DP_LIMIT      12'h1e0
`define NVRB_IDX_SC_OCV_LIM    12'h1e1
`define NVRB_IDX_AGE_FC_CFG    12'h1e2
`define NVRB_IDX_SPARE_CFG2    12'h1e4
// locations placed by this block
`define NVRB_IDX_TIMER_H       12'h1f0
`define NVRB_IDX_MM_TEMP       12'h1f1
`define NVRB_IDX_MM_VOLT       12'h1f2
`define NVRB_IDX_MM_CURR       12'h1f3
`define NVRB_IDX_VOLT_TEMP     12'h1f4
`define NVRB_IDX_FCAP_REP      12'h1f5
`define NVRB_IDX_FCAP_NOM      12'h1f6
`define NVRB_IDX_TCURVE        12'h1f7
`define NVRB_IDX_USER0         12'h1f8
`define NVRB_IDX_STATUS        12'h1ff
`define NVRB_USER_WORDS        7

// ==================================================================
// nv_restore_backup_enables fields
`define NVRB_B_ELAPSED_HI      15
`define NVRB_B_MBZ             14
`define NVRB_B_TEMP_EXT        13
`define NVRB_B_VOLT_EXT        12
`define NVRB_B_CURR_EXT        11
`define NVRB_B_AVG_VT          10
`define NVRB_B_FULL_CAP        9
`define NVRB_B_TRACE_COMP      7
`define NVRB_LOG_MAX_HI        5
`define NVRB_LOG_MAX_LO        3
`define NVRB_LOG_SCL_HI        2
`define NVRB_LOG_SCL_LO        0
// nv_restore_enables_first fields
`define NVRB_B0_DESIGN_CAP     0
`define NVRB_B0_AGE_FC         1
`define NVRB_B0_CHG_PRESC      2
// nv_restore_enables_second fields
`define NVRB_B1_TTF            0
`define NVRB_B1_CONVG          1
`define NVRB_B1_GAIN_TC        14
`define NVRB_B1_TEMP_PROT      10

// ==================================================================
// alternate initial values used when a restore is disabled, and the Fibonacci log base term
`define NVRB_ALT_ELAPSED_HI    16'h0000
`define NVRB_ALT_GAIN_TC       16'h0000
`define NVRB_LOG_BASE          16'h0001

`endif

// File: rtl/nvrb_pkg.sv
// nvrb_pkg.sv: types for the nonvolatile restore/backup configuration block.
// assumes: nvrb_map.svh holds all numbers.
`include "nvrb_map.svh"
package nvrb_pkg;
    typedef enum logic [1:0] {
        NVRB_IDLE,
        NVRB_RESTORE,
        NVRB_RUN
    } nvrb_phase_t;

    typedef logic [15:0] nvrb_word_t;
endpackage : nvrb_pkg

// File: rtl/nvrb_core.sv
// nvrb_core.sv: restore/backup configuration, nonvolatile word array and
// restored gauge registers, reached over an AXI4-Lite slave.
// assumes: single clock, synchronous active-high reset; the nonvolatile array
// is modelled by flip-flops that keep their contents across the block's reset.
`timescale 1ns/100ps
`include "nvrb_map.svh"

// Behaviour
// - set enable restores from store, else default
// - elapsed high backed up/restored, else alternate
// - temperature extremes saved on save, never restored
// - voltage extremes saved on save, no restore
// - current extremes saved on save, no restore
// - average voltage/temperature saved on save
// - capacities restore from reported or nominal word
// - trace compensation forces die temperature measurement
// - max and scale set Fibonacci log interval
// - seven dedicated user words always available
// - time-to-full word freed when enable clear
// - age-forecast word freed when enable clear
// - charge current, step words freed both clear
// - design capacity word freed when enable clear
// - converge word freed, default converge applies
// - gain tempco restores from curve word
module nvrb_core #(
    parameter int ADDR_W = 14
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // axi4-lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    // axi4-lite read data
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // gauge live values and save event
    input  wire logic               save_req,
    input  wire nvrb_pkg::nvrb_word_t live_elapsed_time_high,
    input  wire nvrb_pkg::nvrb_word_t live_temp_extremes,
    input  wire nvrb_pkg::nvrb_word_t live_volt_extremes,
    input  wire nvrb_pkg::nvrb_word_t live_curr_extremes,
    input  wire logic [7:0]         live_averaged_cell_voltage,
    input  wire logic [7:0]         live_averaged_temperature,
    input  wire nvrb_pkg::nvrb_word_t live_reported_capacity,
    // restored gauge registers and derived controls
    output nvrb_pkg::nvrb_word_t    elapsed_time_high,
    output nvrb_pkg::nvrb_word_t    learned_capacity,
    output nvrb_pkg::nvrb_word_t    reported_capacity,
    output nvrb_pkg::nvrb_word_t    current_gain_tempco,
    output nvrb_pkg::nvrb_word_t    design_capacity,
    output logic                    die_temp_measure_en,
    output logic                    trace_sense_comp_en,
    output logic                    time_to_full_cfg_en,
    output logic                    converge_empty_en,
    output logic                    temp_region_protect_en,
    output logic [2:0]              log_interval_max,
    output logic [2:0]              log_interval_scale,
    output nvrb_pkg::nvrb_word_t    log_interval,
    output logic                    restore_done
);
    import nvrb_pkg::*;

    localparam int NW = 32;

    // ==================================================================
    // state
    typedef struct packed {
        nvrb_phase_t         phase;
        logic [NW*16-1:0]    nv;
        logic                aw_hold;
        logic                w_hold;
        logic [ADDR_W-1:0]   aw_addr;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        nvrb_word_t          elapsed;
        nvrb_word_t          lcap;
        nvrb_word_t          rcap;
        nvrb_word_t          gtc;
        nvrb_word_t          dcap;
        logic                die_en;
        logic                done;
    } nvrb_state_t;

    nvrb_state_t s_q;
    nvrb_state_t s_d;

    // ==================================================================
    // word slot lookup: each mapped location has one flip-flop word, any other gives 6'h3f
    function automatic logic [5:0] slot_of(input logic [11:0] idx);
        logic [5:0] r;
        r = 6'h3f;
        case (idx)
            `NVRB_IDX_MISC_CFG:    r = 6'h00;
            `NVRB_IDX_DESIGN_CAP:  r = 6'h01;
            `NVRB_IDX_SBS_CFG:     r = 6'h02;
            `NVRB_IDX_RELAX_CFG:   r = 6'h03;
            `NVRB_IDX_CONVG_CFG:   r = 6'h04;
            `NVRB_IDX_NV_CFG0:     r = 6'h05;
            `NVRB_IDX_NV_CFG1:     r = 6'h06;
            `NVRB_IDX_NV_CFG2:     r = 6'h07;
            `NVRB_IDX_FULL_SOC_TH: r = 6'h08;
            `NVRB_IDX_TTF_CFG:     r = 6'h09;
            `NVRB_IDX_JEITA_C:     r = 6'h0a;
            `NVRB_IDX_STEP_CHG:    r = 6'h0b;
            `NVRB_IDX_DP_LIMIT:    r = 6'h0c;
            `NVRB_IDX_SC_OCV_LIM:  r = 6'h0d;
            `NVRB_IDX_AGE_FC_CFG:  r = 6'h0e;
            `NVRB_IDX_SPARE_CFG2:  r = 6'h0f;
            `NVRB_IDX_TIMER_H:     r = 6'h10;
            `NVRB_IDX_MM_TEMP:     r = 6'h11;
            `NVRB_IDX_MM_VOLT:     r = 6'h12;
            `NVRB_IDX_MM_CURR:     r = 6'h13;
            `NVRB_IDX_VOLT_TEMP:   r = 6'h14;
            `NVRB_IDX_FCAP_REP:    r = 6'h15;
            `NVRB_IDX_FCAP_NOM:    r = 6'h16;
            `NVRB_IDX_TCURVE:      r = 6'h17;
            default: begin
                if (idx >= `NVRB_IDX_USER0 && idx < `NVRB_IDX_USER0 + 12'(`NVRB_USER_WORDS)) begin
                    r = 6'h18 + 6'(idx - `NVRB_IDX_USER0);
                end
            end
        endcase
        return r;
    endfunction : slot_of

    function automatic nvrb_word_t nvw(input logic [NW*16-1:0] a, input logic [5:0] k);
        return a[k*16 +: 16];
    endfunction : nvw

    // ==================================================================
    // decoded configuration
    nvrb_word_t cfg0;
    nvrb_word_t cfg1;
    nvrb_word_t cfg2;
    assign cfg0 = nvw(s_q.nv, 6'h05);
    assign cfg1 = nvw(s_q.nv, 6'h06);
    assign cfg2 = nvw(s_q.nv, 6'h07);

    // Fibonacci spacing, scale shifts the max-th term
    logic [15:0] fib_tab [0:7];
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_fib
            if (gi < 2) begin : g_base
                assign fib_tab[gi] = `NVRB_LOG_BASE;
            end else begin : g_sum
                assign fib_tab[gi] = fib_tab[gi-1] + fib_tab[gi-2];
            end
        end
    endgenerate

    assign log_interval_max       = cfg2[`NVRB_LOG_MAX_HI:`NVRB_LOG_MAX_LO];
    assign log_interval_scale     = cfg2[`NVRB_LOG_SCL_HI:`NVRB_LOG_SCL_LO];
    assign log_interval           = fib_tab[log_interval_max] << log_interval_scale;
    assign trace_sense_comp_en    = cfg2[`NVRB_B_TRACE_COMP];
    // time-to-full parameters fall back to defaults when clear
    assign time_to_full_cfg_en    = cfg1[`NVRB_B1_TTF];
    assign converge_empty_en      = cfg1[`NVRB_B1_CONVG];
    assign temp_region_protect_en = cfg1[`NVRB_B1_TEMP_PROT];

    assign elapsed_time_high   = s_q.elapsed;
    assign learned_capacity    = s_q.lcap;
    assign reported_capacity   = s_q.rcap;
    assign current_gain_tempco = s_q.gtc;
    assign design_capacity     = s_q.dcap;
    assign die_temp_measure_en = s_q.die_en;
    assign restore_done        = s_q.done;

    // ==================================================================
    // axi4-lite handshakes
    assign s_axi_awready = !s_q.aw_hold && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_hold && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    // ==================================================================
    // next state
    always_comb begin
        logic        aw_ok;
        logic        w_ok;
        logic [11:0] widx;
        logic [11:0] ridx;
        logic [5:0]  ws;
        logic [5:0]  rs;
        nvrb_word_t  wv;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        widx  = 12'h000;
        ridx  = 12'h000;
        ws    = 6'h3f;
        rs    = 6'h3f;
        wv    = 16'h0000;
        s_d   = s_q;

        // write channel capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_hold = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_hold = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        aw_ok = s_d.aw_hold;
        w_ok  = s_d.w_hold;
        if (aw_ok && w_ok && !s_q.bvalid) begin
            widx = 12'(s_d.aw_addr >> 2);
            ws   = slot_of(widx);
            s_d.aw_hold = 1'b0;
            s_d.w_hold  = 1'b0;
            s_d.bvalid  = 1'b1;
            if (ws == 6'h3f) begin
                s_d.bresp = 2'h2;
            end else begin
                s_d.bresp = 2'h0;
                wv = nvw(s_q.nv, ws);
                if (s_d.w_strb[0]) begin
                    wv[7:0] = s_d.w_data[7:0];
                end
                if (s_d.w_strb[1]) begin
                    wv[15:8] = s_d.w_data[15:8];
                end
                if (ws == 6'h07) begin
                    wv[`NVRB_B_MBZ] = 1'b0;
                end
                s_d.nv[ws*16 +: 16] = wv;
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            ridx = 12'(s_axi_araddr >> 2);
            rs   = slot_of(ridx);
            s_d.rvalid = 1'b1;
            if (ridx == `NVRB_IDX_STATUS) begin
                s_d.rdata = {30'h0, s_q.die_en, s_q.done};
                s_d.rresp = 2'h0;
            end else if (rs == 6'h3f) begin
                s_d.rdata = 32'h0;
                s_d.rresp = 2'h2;
            end else begin
                s_d.rdata = {16'h0, nvw(s_q.nv, rs)};
                s_d.rresp = 2'h0;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        case (s_q.phase)
            NVRB_IDLE: begin
                s_d.phase = NVRB_RESTORE;
            end
            NVRB_RESTORE: begin
                s_d.elapsed = cfg2[`NVRB_B_ELAPSED_HI] ? nvw(s_q.nv, 6'h10) : `NVRB_ALT_ELAPSED_HI;
                if (cfg2[`NVRB_B_FULL_CAP]) begin
                    s_d.lcap = nvw(s_q.nv, 6'h15);
                    s_d.rcap = nvw(s_q.nv, 6'h15);
                end else begin
                    s_d.lcap = nvw(s_q.nv, 6'h16);
                    s_d.rcap = nvw(s_q.nv, 6'h16);
                end
                s_d.gtc = cfg1[`NVRB_B1_GAIN_TC] ? nvw(s_q.nv, 6'h17) : `NVRB_ALT_GAIN_TC;
                // design capacity remembered only when enabled
                s_d.dcap = cfg0[`NVRB_B0_DESIGN_CAP] ? nvw(s_q.nv, 6'h01) : nvw(s_q.nv, 6'h16);
                s_d.die_en = cfg2[`NVRB_B_TRACE_COMP];
                s_d.done   = 1'b1;
                s_d.phase  = NVRB_RUN;
            end
            NVRB_RUN: begin
                s_d.elapsed = live_elapsed_time_high;
                s_d.rcap    = live_reported_capacity;
                if (save_req) begin
                    if (cfg2[`NVRB_B_ELAPSED_HI]) begin
                        s_d.nv[6'h10*16 +: 16] = live_elapsed_time_high;
                    end
                    if (cfg2[`NVRB_B_TEMP_EXT]) begin
                        s_d.nv[6'h11*16 +: 16] = live_temp_extremes;
                    end
                    if (cfg2[`NVRB_B_VOLT_EXT]) begin
                        s_d.nv[6'h12*16 +: 16] = live_volt_extremes;
                    end
                    if (cfg2[`NVRB_B_CURR_EXT]) begin
                        s_d.nv[6'h13*16 +: 16] = live_curr_extremes;
                    end
                    if (cfg2[`NVRB_B_AVG_VT]) begin
                        s_d.nv[6'h14*16 +: 16] = {live_averaged_cell_voltage, live_averaged_temperature};
                    end
                    if (cfg2[`NVRB_B_FULL_CAP]) begin
                        s_d.nv[6'h15*16 +: 16] = live_reported_capacity;
                    end
                end
            end
            default: begin
                s_d.phase = NVRB_IDLE;
            end
        endcase
    end

    // ==================================================================
    // registers; the word array keeps its contents across reset like nvm
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q.phase   <= NVRB_IDLE;
            s_q.nv      <= s_q.nv;
            s_q.aw_hold <= 1'b0;
            s_q.w_hold  <= 1'b0;
            s_q.aw_addr <= '0;
            s_q.w_data  <= 32'h0;
            s_q.w_strb  <= 4'h0;
            s_q.bvalid  <= 1'b0;
            s_q.bresp   <= 2'h0;
            s_q.rvalid  <= 1'b0;
            s_q.rdata   <= 32'h0;
            s_q.rresp   <= 2'h0;
            s_q.elapsed <= 16'h0000;
            s_q.lcap    <= 16'h0000;
            s_q.rcap    <= 16'h0000;
            s_q.gtc     <= 16'h0000;
            s_q.dcap    <= 16'h0000;
            s_q.die_en  <= 1'b0;
            s_q.done    <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : nvrb_core

// File: sim/nvrb_checker.sv
// nvrb_checker.sv: handshake and restore timing checks on the core's ports.
// assumes: bound to nvrb_core; one clock, synchronous active-high rst.
`timescale 1ns/100ps
module nvrb_checker (
    // clock and reset
    input wire logic                 clock,
    input wire logic                 rst,
    // bus
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    // gauge side
    input wire logic                 save_req,
    input wire nvrb_pkg::nvrb_word_t elapsed_time_high,
    input wire logic                 die_temp_measure_en,
    input wire logic                 trace_sense_comp_en,
    input wire logic [2:0]           log_interval_max,
    input wire logic [2:0]           log_interval_scale,
    input wire nvrb_pkg::nvrb_word_t log_interval,
    input wire logic                 restore_done
);
    import nvrb_pkg::*;
    localparam logic [7:0] FIB [8] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0d, 8'h15};
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ==================================================================
    // bus answers
    AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken during response");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    // ==================================================================
    // restore and derived controls
    AST_RST_CLEAR: assert property ($past(rst) |-> !restore_done && elapsed_time_high == 16'h0000)
        else $error("outputs not cleared by reset");
    AST_DONE_TIME: assert property ($past(rst) |-> ##[1:2] restore_done)
        else $error("restore not finished in time");
    AST_TRACE_DIE: assert property ($rose(restore_done) && trace_sense_comp_en |-> ##[0:1] die_temp_measure_en)
        else $error("die temperature measurement not forced");
    AST_LOG_FIB: assert property ((restore_done && $stable(log_interval_max) && $stable(log_interval_scale))[*3]
        |-> log_interval == ({8'h00, FIB[log_interval_max]} << log_interval_scale))
        else $error("log interval wrong");

    COV_TRACE: cover property ($rose(restore_done) && trace_sense_comp_en);
    COV_SAVE: cover property (save_req);
    COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : nvrb_checker

bind nvrb_core nvrb_checker chk_u (
    .clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .save_req, .elapsed_time_high, .die_temp_measure_en, .trace_sense_comp_en,
    .log_interval_max, .log_interval_scale, .log_interval, .restore_done
);

// File: sim/testbench.sv
// testbench.sv: self-checking bench for the restore/backup configuration core.
// assumes: the checker file is compiled alongside and binds itself.
`timescale 1ns/100ps
module testbench;
    import nvrb_pkg::*;
    typedef struct packed {
        logic [11:0] idx;
        logic [15:0] wv;
        logic [15:0] rv;
        logic [1:0]  er;
    } nvrb_row_t;
    localparam int NROW = 17;
    // ==================================================================
    // rows: index, written, read back, response
    localparam nvrb_row_t ROWS [NROW] = '{
        '{12'h1b2, 16'h1234, 16'h1234, 2'h0}, '{12'h1b3, 16'h2345, 16'h2345, 2'h0},
        '{12'h1b4, 16'h3456, 16'h3456, 2'h0}, '{12'h1b6, 16'h4567, 16'h4567, 2'h0},
        '{12'h1b7, 16'h5678, 16'h5678, 2'h0}, '{12'h1c6, 16'h6789, 16'h6789, 2'h0},
        '{12'h1c7, 16'h789a, 16'h789a, 2'h0}, '{12'h1d8, 16'h89ab, 16'h89ab, 2'h0},
        '{12'h1db, 16'h9abc, 16'h9abc, 2'h0}, '{12'h1e0, 16'habcd, 16'habcd, 2'h0},
        '{12'h1e1, 16'hbcde, 16'hbcde, 2'h0}, '{12'h1e2, 16'hcdef, 16'hcdef, 2'h0},
        '{12'h1e4, 16'hdef0, 16'hdef0, 2'h0}, '{12'h1f8, 16'h5a5a, 16'h5a5a, 2'h0},
        '{12'h1fe, 16'ha5a5, 16'ha5a5, 2'h0}, '{12'h1ba, 16'hbbff, 16'hbbff, 2'h0},
        '{12'h1a0, 16'hffff, 16'h0000, 2'h2}
    };
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, save_req = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    nvrb_word_t  lv [6];
    nvrb_word_t  elapsed_time_high, learned_capacity, reported_capacity;
    nvrb_word_t  current_gain_tempco, design_capacity, log_interval;
    logic        die_temp_measure_en, trace_sense_comp_en, time_to_full_cfg_en;
    logic        converge_empty_en, temp_region_protect_en, restore_done;
    logic [2:0]  log_interval_max, log_interval_scale;
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;

    nvrb_core dut_u (
        .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .save_req, .live_elapsed_time_high(lv[0]), .live_temp_extremes(lv[1]), .live_volt_extremes(lv[2]),
        .live_curr_extremes(lv[3]), .live_averaged_cell_voltage(lv[4][15:8]),
        .live_averaged_temperature(lv[4][7:0]), .live_reported_capacity(lv[5]), .elapsed_time_high,
        .learned_capacity, .reported_capacity, .current_gain_tempco, .design_capacity, .die_temp_measure_en,
        .trace_sense_comp_en, .time_to_full_cfg_en, .converge_empty_en, .temp_region_protect_en,
        .log_interval_max, .log_interval_scale, .log_interval, .restore_done
    );

    always #10 clock = ~clock;

    // a hung handshake ends the run here
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end

    // ==================================================================
    // compares and bus tasks
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_data({30'h0, got}, {30'h0, exp});
    endtask : cmp_resp

    task automatic wr(input logic [11:0] i, input logic [15:0] d, input logic [1:0] er);
        @(posedge clock);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        cmp_resp(s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [11:0] i, input logic [15:0] ed, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        cmp_data(s_axi_rdata, {16'h0000, ed});
        cmp_resp(s_axi_rresp, er);
    endtask : rd

    task automatic do_reset(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 8 && restore_done !== 1'b1; k++) @(posedge clock);
        cmp_data({31'h0, restore_done}, 32'h0000_0001);
    endtask : do_reset

    task automatic pulse_save;
        save_req <= 1'b1;
        @(posedge clock);
        save_req <= 1'b0;
    endtask : pulse_save

    task automatic chk(input logic [15:0] et, cap, tc, dc, input logic [10:0] fl, input logic [15:0] li);
        cmp_data({elapsed_time_high, learned_capacity}, {et, cap});
        cmp_data({reported_capacity, current_gain_tempco}, {cap, tc});
        cmp_data({design_capacity, log_interval}, {dc, li});
        cmp_data({21'h0, die_temp_measure_en, trace_sense_comp_en, time_to_full_cfg_en, converge_empty_en,
            temp_region_protect_en, log_interval_max, log_interval_scale}, {21'h0, fl});
    endtask : chk

    task automatic summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // ==================================================================
    // main sequence
    initial begin
        int k;
        foreach (lv[j]) lv[j] <= 16'h0000;
        do_reset(12);
        for (k = 0; k < NROW; k++) begin
            wr(ROWS[k].idx, ROWS[k].wv, ROWS[k].er);
            rd(ROWS[k].idx, ROWS[k].rv, ROWS[k].er);
        end
        // all backups on, age forecast off
        wr(12'h1b8, 16'h0000, 2'h0);
        wr(12'h1ba, 16'hbe00, 2'h0);
        for (k = 0; k < 6; k++) lv[k] <= 16'h1357 + 16'(k * 16'h0111);
        pulse_save();
        for (k = 0; k < 6; k++) rd(12'h1f0 + 12'(k), lv[k], 2'h0);
        // backups off: words keep user data
        wr(12'h1ba, 16'h0000, 2'h0);
        for (k = 0; k < 6; k++) wr(12'h1f0 + 12'(k), 16'hc0d0 + 16'(k), 2'h0);
        for (k = 0; k < 6; k++) lv[k] <= 16'hffff;
        pulse_save();
        for (k = 0; k < 6; k++) rd(12'h1f0 + 12'(k), 16'hc0d0 + 16'(k), 2'h0);
        // restore with the enables set, mid-run reset
        wr(12'h1ba, 16'h82bb, 2'h0);
        wr(12'h1b9, 16'h4403, 2'h0);
        wr(12'h1b8, 16'h0001, 2'h0);
        wr(12'h1b3, 16'ha00b, 2'h0);
        for (k = 0; k < 8; k++) wr(12'h1f0 + 12'(k), 16'ha000 + 16'(k), 2'h0);
        do_reset(2);
        chk(16'ha000, 16'ha005, 16'ha007, 16'ha00b, 11'h7fb, 16'h00a8);
        rd(12'h1ff, 16'h0003, 2'h0);
        // enables clear: alternates apply
        for (k = 0; k < 3; k++) wr(12'h1b8 + 12'(k), 16'h0000, 2'h0);
        do_reset(2);
        chk(16'h0000, 16'ha006, 16'h0000, 16'ha006, 11'h000, 16'h0001);
        summarize();
    end
endmodule : testbench
